// ===== hdl/bgo_pkg.sv
package bgo_pkg;
	// Serial word layout
	localparam int  WORD_BITS      = 16;
	localparam int  ADDR_HI        = 15;
	localparam int  ADDR_LO        = 14;
	localparam int  WR_BIT         = 13;
	localparam logic [1:0] ADDR_CFG0 = 2'h0;
	localparam logic [1:0] ADDR_CFG1 = 2'h1;
	localparam logic [1:0] ADDR_MASK = 2'h2;
	localparam logic [1:0] ADDR_RUN  = 2'h3;
	// Field positions
	localparam int  BLANK_HI       = 12;
	localparam int  BLANK_LO       = 7;
	localparam int  DEAD_HI        = 6;
	localparam int  DEAD_LO        = 0;
	localparam int  BOOT_OFF_BIT   = 8;
	localparam int  RUN_HI         = 5;
	localparam int  DIAG_BOOT_HI   = 8;
	localparam int  DIAG_BOOT_LO   = 6;
	// Reset values of the 14 data bits of each register
	localparam logic [13:0] CFG0_RST = 14'h1020;
	localparam logic [13:0] CFG1_RST = 14'h1820;
	localparam logic [13:0] MASK_RST = 14'h0000;
	localparam logic [13:0] RUN_RST  = 14'h0000;
	// Timing
	localparam int  CLK_NS         = 8;
	localparam int  BLANK_UNIT_NS  = 100;
	localparam int  BOOT_MIN_NS    = 7000;
	localparam int  BOOT_TMO_NS    = 200000;
	localparam int  BOOT_MIN_CYC   = (BOOT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int  BOOT_TMO_CYC   = BOOT_TMO_NS / CLK_NS;
	localparam int  BOOT_CNT_W     = 15;
	localparam int  BLANK_CNT_W    = 10;

	typedef enum logic {
		BOOT_IDLE   = 1'b0,
		BOOT_CHARGE = 1'b1
	} bgo_boot_e;

	// Register image handed to the serial side, frozen during a frame
	typedef struct packed {
		logic        flag_any;
		logic        por;
		logic [13:0] cfg0;
		logic [13:0] cfg1;
		logic [13:0] mask;
		logic [13:0] run;
		logic [13:0] diag;
	} bgo_snap_s;

	// Analog comparator outputs for the three phases, A in bit 0
	typedef struct packed {
		logic [2:0] above_hys;
		logic [2:0] below_th;
	} bgo_boot_s;
endpackage

// ===== hdl/bgo_gate_boot.sv
`timescale 1ns/100ps
// Functional notes
// - With an override bit at 0 the gate follows its logic input pin, except a low side forced on during a recharge.
// - Each override bit is OR-ed with its pin, so a 1 forces that gate high.
// - A new blanking length takes effect at the first gate turn-on after its transfer ends.
// - Every phase's bootstrap voltage is compared with its threshold at all times.
// - A phase below threshold gets its low side forced on until above threshold plus hysteresis.
// - A recharge lasts at least the minimum time, longer if the voltage is slow to recover.
// - A recharge still below threshold after the timeout flags that phase's bootstrap fault.
// - With management off the voltages are still monitored and faults still reported.
// - With the write flag at 0 the addressed register is returned after the two status bits.
// - Management-off bit at 0 (default) enables bootstrap management, at 1 disables it.
// - Blanking time is the six-bit field times 100 ns.
// - Each phase has its own bootstrap fault bit in the diagnostic word.
module bgo_gate_boot #(
	parameter int BOOT_TMO = bgo_pkg::BOOT_TMO_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              sck,
	input  wire logic              strobe_n,
	input  wire logic              sdi,
	output logic                   sdo,
	output logic                   sdo_oe,
	input  wire logic [5:0]        gate_in,
	input  wire bgo_pkg::bgo_boot_s boot_cmp,
	output logic [5:0]             gate_drive,
	output logic                   blanking_active,
	output logic [6:0]             deadtime_length,
	output logic [2:0]             boot_fault
);
	import bgo_pkg::*;

	// Blanking length field to clock cycles, rounded up
	function automatic logic [BLANK_CNT_W-1:0] blank_cycles(
		input logic [5:0] n
	);
		int t;
		t = (int'(n) * BLANK_UNIT_NS + CLK_NS - 1) / CLK_NS;
		return t[BLANK_CNT_W-1:0];
	endfunction

	// ---------------- Link domain (sck) ----------------
	logic [4:0]  rx_cnt, next_rx_cnt;
	logic [15:0] rx_sh, next_rx_sh;
	logic [1:0]  lk_addr, next_lk_addr;
	logic        lk_wr, next_lk_wr;
	logic        rx_done, next_rx_done;
	logic [15:0] rx_word;
	logic [4:0]  tx_cnt, next_tx_cnt;
	logic        next_sdo;
	logic [15:0] tx_word;
	bgo_snap_s   snap;
	// Receive: sdi sampled on rising sck, MSB first; extra bits ignored
	always_comb begin
		next_rx_cnt  = rx_cnt;
		next_rx_sh   = rx_sh;
		next_lk_addr = lk_addr;
		next_lk_wr   = lk_wr;
		next_rx_done = rx_done;
		if (rx_cnt < 5'(WORD_BITS)) begin
			next_rx_cnt = rx_cnt + 5'h01;
			next_rx_sh  = {rx_sh[14:0], sdi};
		end
		if (rx_cnt == 5'h01)
			next_lk_addr = {rx_sh[0], sdi};
		if (rx_cnt == 5'h02)
			next_lk_wr = sdi;
		if (rx_cnt == 5'(WORD_BITS - 1))
			next_rx_done = 1'b1;
	end

	// Frame state is cleared while the strobe is high; sck may stand still
	always_ff @(posedge sck or posedge strobe_n) begin
		if (strobe_n) begin
			rx_cnt  <= 5'h00;
			rx_sh   <= 16'h0000;
			lk_addr <= 2'h0;
			lk_wr   <= 1'b0;
			rx_done <= 1'b0;
		end else begin
			rx_cnt  <= next_rx_cnt;
			rx_sh   <= next_rx_sh;
			lk_addr <= next_lk_addr;
			lk_wr   <= next_lk_wr;
			rx_done <= next_rx_done;
		end
	end

	// Word copy survives the strobe so the system side can read it late
	always_ff @(posedge sck) begin
		if (!strobe_n && rx_cnt == 5'(WORD_BITS - 1))
			rx_word <= next_rx_sh;
	end

	// Outgoing word; the write flag is not known for bit 13, which is 0
	// in both the register and the diagnostic image anyway
	always_comb begin
		logic [13:0] body;
		body = 14'h0000;
		if (lk_wr) begin
			body = snap.diag;
		end else begin
			case (lk_addr)
				ADDR_CFG0: body = snap.cfg0;
				ADDR_CFG1: body = snap.cfg1;
				ADDR_MASK: body = snap.mask;
				ADDR_RUN:  body = snap.run;
				default:   body = 14'h0000;
			endcase
		end
		tx_word     = {snap.flag_any, snap.por, body};
		next_sdo    = tx_word[4'(15 - tx_cnt)];
		next_tx_cnt = (tx_cnt < 5'(WORD_BITS - 1)) ? tx_cnt + 5'h01 : tx_cnt;
	end

	// sck idles high, so each falling edge presents the next bit
	always_ff @(negedge sck or posedge strobe_n) begin
		if (strobe_n) begin
			tx_cnt <= 5'h00;
			sdo    <= 1'b0;
		end else begin
			tx_cnt <= next_tx_cnt;
			sdo    <= next_sdo;
		end
	end

	// ---------------- System domain (clk) ----------------
	logic [1:0]  stb_sy;
	logic [2:0]  done_sy;
	logic [5:0]  pin_s1, pin_s2;
	bgo_boot_s   cmp_s1, cmp_s2;
	logic        rx_evt;
	// Two-flop synchronisers; done gets a third stage for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stb_sy  <= 2'h3;
			done_sy <= 3'h0;
			pin_s1  <= 6'h00;
			pin_s2  <= 6'h00;
			cmp_s1  <= '0;
			cmp_s2  <= '0;
		end else begin
			stb_sy  <= {stb_sy[0], strobe_n};
			done_sy <= {done_sy[1:0], rx_done};
			pin_s1  <= gate_in;
			pin_s2  <= pin_s1;
			cmp_s1  <= boot_cmp;
			cmp_s2  <= cmp_s1;
		end
	end
	assign rx_evt = done_sy[1] & ~done_sy[2];

	logic [13:0]     cfg0, cfg1, mask, run, diag;
	logic [13:0]     next_cfg0, next_cfg1, next_mask, next_run;
	logic            por, next_por, mgmt_on;
	logic [2:0]      fault, next_fault, boot_force;
	bgo_boot_e       bst [3];
	bgo_boot_e       next_bst [3];
	logic [BOOT_CNT_W-1:0] bcnt [3];
	logic [BOOT_CNT_W-1:0] next_bcnt [3];
	assign mgmt_on = ~cfg1[BOOT_OFF_BIT];
	assign diag    = {5'h00, fault, 6'h00};
	// Register writes and the bootstrap supervisor, one per phase
	always_comb begin
		logic [1:0] wa;
		wa         = rx_word[ADDR_HI:ADDR_LO];
		next_cfg0  = cfg0;
		next_cfg1  = cfg1;
		next_mask  = mask;
		next_run   = run;
		next_por   = por;
		next_fault = fault;
		boot_force = 3'h0;
		if (rx_evt && rx_word[WR_BIT]) begin
			case (wa)
				ADDR_CFG0: next_cfg0 = {1'b0, rx_word[12:0]};
				ADDR_CFG1: next_cfg1 = {1'b0, rx_word[12:0]};
				ADDR_MASK: next_mask = {1'b0, rx_word[12:0]};
				ADDR_RUN:  next_run  = {8'h00, rx_word[RUN_HI:0]};
				default:   next_run  = run;
			endcase
			// Diagnostic word was returned, so its latched bits clear
			next_por   = 1'b0;
			next_fault = 3'h0;
		end
		for (int p = 0; p < 3; p++) begin
			next_bst[p]  = bst[p];
			next_bcnt[p] = bcnt[p];
			case (bst[p])
				BOOT_IDLE: begin
					if (cmp_s2.below_th[p]) begin
						next_bst[p]  = BOOT_CHARGE;
						next_bcnt[p] = '0;
					end
				end
				BOOT_CHARGE: begin
					boot_force[p] = mgmt_on;
					if (bcnt[p] != BOOT_CNT_W'(BOOT_TMO))
						next_bcnt[p] = bcnt[p] + 1'b1;
					// Hold for the minimum even if the voltage recovers
					if (cmp_s2.above_hys[p] &&
					    (!mgmt_on || bcnt[p] >= BOOT_CNT_W'(BOOT_MIN_CYC - 1)))
						next_bst[p] = BOOT_IDLE;
					// Set after clear: a fault never gets lost
					if (bcnt[p] == BOOT_CNT_W'(BOOT_TMO - 1) &&
					    cmp_s2.below_th[p] && !mask[DIAG_BOOT_HI - p])
						next_fault[2 - p] = 1'b1;
				end
				default: next_bst[p] = BOOT_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg0  <= CFG0_RST;
			cfg1  <= CFG1_RST;
			mask  <= MASK_RST;
			run   <= RUN_RST;
			por   <= 1'b1;
			fault <= 3'h0;
			for (int p = 0; p < 3; p++) begin
				bst[p]  <= BOOT_IDLE;
				bcnt[p] <= '0;
			end
		end else begin
			cfg0  <= next_cfg0;
			cfg1  <= next_cfg1;
			mask  <= next_mask;
			run   <= next_run;
			por   <= next_por;
			fault <= next_fault;
			bst   <= next_bst;
			bcnt  <= next_bcnt;
		end
	end

	// Gate outputs, blanking and the frozen image for the serial side
	logic [5:0]             next_gate;
	logic [BLANK_CNT_W-1:0] blank_cnt, next_blank_cnt;
	logic                   next_blanking;
	bgo_snap_s              next_snap;
	always_comb begin
		next_gate = pin_s2 | run[5:0];
		for (int p = 0; p < 3; p++)
			next_gate[4 - 2 * p] = next_gate[4 - 2 * p] | boot_force[p];
		next_blank_cnt = (blank_cnt != '0) ? blank_cnt - 1'b1 : blank_cnt;
		// Length is read from the register only at a turn-on edge
		if ((next_gate & ~gate_drive) != 6'h00)
			next_blank_cnt = blank_cycles(cfg0[BLANK_HI:BLANK_LO]);
		next_blanking = (next_blank_cnt != '0);
		next_snap = '{flag_any: por | (|diag), por: por, cfg0: cfg0,
		              cfg1: cfg1, mask: mask, run: run, diag: diag};
		if (!stb_sy[1])
			next_snap = snap; // Held steady while a frame is open
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gate_drive      <= 6'h00;
			blank_cnt       <= '0;
			blanking_active <= 1'b0;
			deadtime_length <= 7'h00;
			boot_fault      <= 3'h0;
			sdo_oe          <= 1'b0;
			snap            <= '0;
		end else begin
			gate_drive      <= next_gate;
			blank_cnt       <= next_blank_cnt;
			blanking_active <= next_blanking;
			deadtime_length <= cfg0[DEAD_HI:DEAD_LO];
			boot_fault      <= fault;
			sdo_oe          <= ~stb_sy[1];
			snap            <= next_snap;
		end
	end

	// ---------------- Checks ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_follow_pin;
		!run[5] |=> gate_drive[5] == $past(pin_s2[5]);
	endproperty
	a_follow_pin: assert property (p_follow_pin)
		else $error("high side A not following its pin");
	property p_force_on;
		run[2] |=> gate_drive[2];
	endproperty
	a_force_on: assert property (p_force_on)
		else $error("override bit did not force gate high");
	property p_blank_load;
		((next_gate & ~gate_drive) != 6'h00) |=>
			blank_cnt == blank_cycles($past(cfg0[BLANK_HI:BLANK_LO]));
	endproperty
	a_blank_load: assert property (p_blank_load)
		else $error("blanking not loaded at turn-on");
	property p_monitor;
		(bst[1] == BOOT_IDLE && cmp_s2.below_th[1]) |=> bst[1] == BOOT_CHARGE;
	endproperty
	a_monitor: assert property (p_monitor)
		else $error("undervoltage on phase B not noticed");
	property p_low_force;
		(bst[0] == BOOT_CHARGE && mgmt_on) |=> gate_drive[4];
	endproperty
	a_low_force: assert property (p_low_force)
		else $error("low side A not forced during recharge");
	property p_min_charge;
		$rose(bst[0] == BOOT_CHARGE) && mgmt_on |->
			(bst[0] == BOOT_CHARGE)[*8];
	endproperty
	a_min_charge: assert property (p_min_charge)
		else $error("recharge ended before minimum time");
	property p_timeout;
		(bst[1] == BOOT_CHARGE && bcnt[1] == BOOT_CNT_W'(BOOT_TMO - 1) &&
		 cmp_s2.below_th[1] && !mask[DIAG_BOOT_HI - 1]) |=>
			fault[1] ##1 boot_fault[1];
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("bootstrap fault B not flagged at timeout");
	property p_off_no_force;
		(!mgmt_on && run[2] == 1'b0 && pin_s2[2] == 1'b0) |=> !gate_drive[2];
	endproperty
	a_off_no_force: assert property (p_off_no_force)
		else $error("low side B forced with management off");
	property p_run_write;
		(rx_evt && rx_word[15:13] == 3'h7) |=> run[5:0] == $past(rx_word[5:0]);
	endproperty
	a_run_write: assert property (p_run_write)
		else $error("override register write lost");
	c_override: cover property (rx_evt && rx_word[15:13] == 3'h7);
	c_recharge: cover property ($fell(bst[0] == BOOT_CHARGE));
	c_fault:    cover property ($rose(fault[1]));
	c_blank:    cover property ($fell(blanking_active));
endmodule // bgo_gate_boot

// ===== tb/bgo_ctrl_model.sv
`timescale 1ns/100ps
// Controller on the far side of the serial link; sck only toggles in frames
module bgo_ctrl_model (
	output logic      sck,
	output logic      strobe_n,
	output logic      sdi,
	input  wire logic sdo
);
	// Link idles with sck high and no frame selected
	initial begin
		sck = 1'b1;
		strobe_n = 1'b1;
		sdi = 1'b0;
	end

	// One 16-bit word, MSB first; 40 ns lead covers the 3 clk frame setup
	// Dead time is left at its safe default, blanking rewritten freely
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		#3;
		strobe_n = 1'b0;
		#40;
		for (int i = 15; i >= 0; i--) begin
			sck = 1'b0;
			sdi = w[i];
			#40;
			sck = 1'b1;
			r[i] = sdo;
			#40;
		end
		#80;
		strobe_n = 1'b1;
		sdi = ~sdi; // Released line must not keep its last level
		#80;
	endtask
endmodule // bgo_ctrl_model

// ===== tb/test_bridge_gate_override_bootstrap_mgmt.sv
`timescale 1ns/100ps
// Bench for gate override and bootstrap supervision
module test_bridge_gate_override_bootstrap_mgmt;
	import bgo_pkg::*;
	localparam int TMO = 2000;
	logic             clk;
	logic             rst_n;
	logic             sck;
	logic             strobe_n;
	logic             sdi;
	logic             sdo;
	logic             sdo_oe;
	logic [5:0]       gate_in;
	bgo_boot_s        boot_cmp;
	logic [5:0]       gate_drive;
	logic             blanking_active;
	logic [6:0]       deadtime_length;
	logic [2:0]       boot_fault;
	int               num_errors;
	int               n_checks;

	bgo_ctrl_model ctrl (.sck(sck), .strobe_n(strobe_n), .sdi(sdi), .sdo(sdo));

	// Short timeout keeps the fault scenario brief
	bgo_gate_boot #(.BOOT_TMO(TMO)) DUT (
		.clk(clk), .rst_n(rst_n), .sck(sck), .strobe_n(strobe_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .gate_in(gate_in),
		.boot_cmp(boot_cmp), .gate_drive(gate_drive),
		.blanking_active(blanking_active),
		.deadtime_length(deadtime_length), .boot_fault(boot_fault));

	// 125 MHz system clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk_word(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bits(input string nm, input logic [6:0] e,
		input logic [6:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_int(input string nm, input int e, input int g);
		n_checks++;
		if (g != e) begin
			num_errors++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Power-on image: both status bits set, config 0 at its default
	task automatic t_reset();
		logic [15:0] r;
		chk_bits("sdo enable idle", 7'h00, {6'h00, sdo_oe});
		// Output enable must rise while the frame is still open
		fork
			ctrl.xfer(16'h0000, r);
			begin
				wait_clk(10);
				chk_bits("sdo enable", 7'h01, {6'h00, sdo_oe});
			end
		join
		chk_bits("sdo enable off", 7'h00, {6'h00, sdo_oe});
		chk_word("cfg0 read", {2'b11, 1'b0, CFG0_RST[12:0]}, r);
		chk_bits("dead time", 7'h20, deadtime_length);
		$display("Test reset done");
	endtask

	// Pins alone, then override OR-ed with pins, then override cleared
	task automatic t_gates();
		logic [15:0] r;
		@(negedge clk);
		gate_in = 6'h2A;
		wait_clk(4);
		chk_bits("pin path", {1'b0, 6'h2A}, {1'b0, gate_drive});
		ctrl.xfer(16'hE015, r);
		chk_word("first diag", 16'hC000, r);
		wait_clk(6);
		chk_bits("or path", {1'b0, 6'h3F}, {1'b0, gate_drive});
		gate_in = 6'h00;
		wait_clk(4);
		chk_bits("force only", {1'b0, 6'h15}, {1'b0, gate_drive});
		ctrl.xfer(16'hC000, r);
		chk_word("override read", 16'h0015, r);
		ctrl.xfer(16'hE000, r);
		wait_clk(6);
		chk_bits("released", 7'h00, {1'b0, gate_drive});
		$display("Test gates done");
	endtask

	// New blanking of 3 units replaces the default 32 at next turn-on
	task automatic t_blank();
		logic [15:0] r;
		int          n;
		n = 0;
		ctrl.xfer(16'h21A0, r);
		ctrl.xfer(16'h0000, r);
		chk_word("cfg0 back", 16'h01A0, r);
		@(negedge clk);
		gate_in = 6'h01;
		for (int i = 0; i < 10 && blanking_active !== 1'b1; i++) begin
			@(negedge clk);
		end
		while (blanking_active === 1'b1 && n < 500) begin
			n++;
			@(negedge clk);
		end
		if (n >= 500) begin
			num_errors++;
			give_verdict();
		end
		chk_int("blank cycles", (3 * BLANK_UNIT_NS + CLK_NS - 1) / CLK_NS, n);
		gate_in = 6'h00;
		$display("Test blanking done");
	endtask

	// Managed recharge holds the low side for the minimum time
	task automatic t_boot_on();
		@(negedge clk);
		boot_cmp = '{3'b110, 3'b001};
		wait_clk(10);
		chk_bits("charge force", 7'h10, {1'b0, gate_drive});
		boot_cmp = '{3'b111, 3'b000};
		wait_clk(830);
		chk_bits("min charge", 7'h10, {1'b0, gate_drive});
		wait_clk(60);
		chk_bits("charge end", 7'h00, {1'b0, gate_drive});
		chk_bits("no fault", 7'h00, {4'b0, boot_fault});
		$display("Test managed charge done");
	endtask

	// Management off: no force, yet phase B still times out to a fault
	task automatic t_boot_off();
		logic [15:0] r;
		ctrl.xfer(16'h6920, r);
		@(negedge clk);
		boot_cmp = '{3'b101, 3'b010};
		wait_clk(100);
		chk_bits("no force", 7'h00, {1'b0, gate_drive});
		wait_clk(TMO);
		chk_bits("fault b", 7'h02, {4'b0, boot_fault});
		boot_cmp = '{3'b111, 3'b000};
		wait_clk(5);
		ctrl.xfer(16'hA000, r);
		chk_word("diag word", 16'h8080, r);
		wait_clk(6);
		chk_bits("fault clear", 7'h00, {4'b0, boot_fault});
		$display("Test unmanaged fault done");
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		gate_in = 6'h00;
		boot_cmp = '{3'b111, 3'b000};
		num_errors = 0;
		n_checks = 0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		wait_clk(4);
		t_reset();
		t_gates();
		t_blank();
		t_boot_on();
		t_boot_off();
		give_verdict();
	end
endmodule // test_bridge_gate_override_bootstrap_mgmt
